// *** design/sfr_byte_buf.sv ***
// Small FIFO between the array data source and the serial shifter
`timescale 1ns/1ps
`default_nettype none
`include "sfr_params.svh"

module sfr_byte_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SFR_BUF_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  import sfr_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (flush_i) begin
      next_count = '0;
    end else if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
    end else begin
      count <= next_count;
      // Registered ready: full is known one edge ahead from the count
      in_ready_o <= (next_count != CW'(DEPTH));
      if (flush_i) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (push) begin
          wr_ptr <= bump(wr_ptr);
        end
        if (pop) begin
          rd_ptr <= bump(rd_ptr);
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (push && !flush_i) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule : sfr_byte_buf
`default_nettype wire

// *** design/sfr_read_front.sv ***
// Read-command front end of a serial NOR flash, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "sfr_params.svh"

module sfr_read_front #(
  parameter int BUF_DEPTH = `SFR_BUF_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] dq_i,
  input wire logic busy_i,
  input wire logic quad_enable_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o,
  output logic write_protect_o,
  output logic hold_o,
  output logic qpi_mode_o,
  output logic cont_mode_o,
  output logic fetch_valid_o,
  output logic [23:0] fetch_addr_o,
  input wire logic fetch_ready_i,
  input wire logic array_valid_i,
  input wire logic [7:0] array_data_i,
  output logic array_ready_o
);
  import sfr_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] d,
                                           input sfr_lanes_t n);
    case (n)
      `SFR_LANES_2: return {sh[21:0], d[1:0]};
      `SFR_LANES_4: return {sh[19:0], d};
      default: return {sh[22:0], d[0]};
    endcase
  endfunction : shift_in

  function automatic logic [3:0] lane_bits(input logic [7:0] b, input sfr_lanes_t n);
    case (n)
      `SFR_LANES_2: return {2'h0, b[7:6]};
      `SFR_LANES_4: return b[7:4];
      default: return {2'h0, b[7], 1'b0};
    endcase
  endfunction : lane_bits

  function automatic logic [3:0] lane_mask(input sfr_lanes_t n);
    case (n)
      `SFR_LANES_2: return `SFR_MASK_2;
      `SFR_LANES_4: return `SFR_MASK_4;
      default: return `SFR_MASK_1;
    endcase
  endfunction : lane_mask

  function automatic sfr_cmd_t decode(input logic [7:0] op, input logic qpi);
    sfr_cmd_t c;
    c = '0;
    c.addr_lanes = `SFR_LANES_1;
    c.data_lanes = `SFR_LANES_1;
    case (op)
      `SFR_OP_READ: begin
        c.ok = !qpi;
      end
      `SFR_OP_FAST: begin
        c.ok = 1'b1;
        c.dummy = qpi ? `SFR_QPI_FAST_DUMMY : `SFR_SPI_DUMMY;
        if (qpi) begin
          c.addr_lanes = `SFR_LANES_4;
          c.data_lanes = `SFR_LANES_4;
        end
      end
      `SFR_OP_DUAL_OUT: begin
        c.ok = !qpi;
        c.dummy = `SFR_SPI_DUMMY;
        c.data_lanes = `SFR_LANES_2;
      end
      `SFR_OP_DUAL_IO: begin
        c.ok = !qpi;
        c.addr_lanes = `SFR_LANES_2;
        c.data_lanes = `SFR_LANES_2;
        c.dummy = `SFR_DIO_DUMMY;
      end
      `SFR_OP_QUAD_OUT: begin
        c.ok = !qpi;
        c.dummy = `SFR_SPI_DUMMY;
        c.data_lanes = `SFR_LANES_4;
      end
      `SFR_OP_QUAD_IO: begin
        c.ok = 1'b1;
        c.addr_lanes = `SFR_LANES_4;
        c.data_lanes = `SFR_LANES_4;
        c.has_mode = 1'b1;
        c.dummy = `SFR_QIO_DUMMY;
      end
      default: begin
        c.ok = 1'b0;
      end
    endcase
    return c;
  endfunction : decode

  // --------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic sclk_prev;
  logic cs_prev;
  logic sclk_s;
  logic cs_s;
  logic [3:0] dq_s;
  logic rise;
  logic fall;
  logic cs_rise;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= `SFR_SYNC_RESET;
      sync2 <= `SFR_SYNC_RESET;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sync1 <= {sclk_i, cs_n_i, dq_i};
      sync2 <= sync1;
      sclk_prev <= sync2[5];
      cs_prev <= sync2[4];
    end
  end

  assign sclk_s = sync2[5];
  assign cs_s = sync2[4];
  assign dq_s = sync2[3:0];
  assign rise = sclk_s & ~sclk_prev;
  assign fall = ~sclk_s & sclk_prev;
  assign cs_rise = cs_s & ~cs_prev;

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  sfr_state_t state;
  sfr_cmd_t cmd;
  sfr_cmd_t cmd_now;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [23:0] sh;
  logic [23:0] next_sh;
  sfr_lanes_t in_lanes;
  logic [7:0] op_now;
  logic cmd_done;
  logic addr_done;
  logic mode_done;
  logic ones_seen;
  logic qpi;
  logic cont;

  always_comb begin
    case (state)
      ST_CMD: in_lanes = qpi ? `SFR_LANES_4 : `SFR_LANES_1;
      ST_ADDR: in_lanes = cmd.addr_lanes;
      ST_MODE: in_lanes = cmd.addr_lanes;
      default: in_lanes = `SFR_LANES_1;
    endcase
  end

  assign next_sh = shift_in(sh, dq_s, in_lanes);
  assign next_cnt = 5'(cnt + 5'(in_lanes));
  assign op_now = next_sh[7:0];
  assign cmd_now = decode(op_now, qpi);
  assign cmd_done = !cs_s && rise && (state == ST_CMD) && (next_cnt == `SFR_OP_BITS);
  assign addr_done = !cs_s && rise && (state == ST_ADDR) && (next_cnt == `SFR_ADDR_BITS);
  assign mode_done = !cs_s && rise && (state == ST_MODE) && (next_cnt == `SFR_MODE_BITS);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cmd <= '0;
      cnt <= '0;
      sh <= '0;
    end else if (cs_s) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= '0;
          sh <= '0;
          if (cont) begin
            cmd <= decode(`SFR_OP_QUAD_IO, 1'b0);
            state <= ST_ADDR;
          end else begin
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (rise) begin
            cnt <= next_cnt;
            sh <= next_sh;
          end
          if (cmd_done) begin
            cnt <= '0;
            cmd <= cmd_now;
            // Refused reads just sit out the frame, the write cycle runs on
            state <= (cmd_now.ok && !busy_i) ? ST_ADDR : ST_IGNORE;
          end
        end
        ST_ADDR: begin
          if (rise) begin
            cnt <= next_cnt;
            sh <= next_sh;
          end
          if (addr_done) begin
            cnt <= '0;
            if (cmd.has_mode) begin
              state <= ST_MODE;
            end else if (cmd.dummy == 4'h0) begin
              state <= ST_DATA;
            end else begin
              state <= ST_DUMMY;
            end
          end
        end
        ST_MODE: begin
          if (rise) begin
            cnt <= next_cnt;
            sh <= next_sh;
          end
          if (mode_done) begin
            cnt <= '0;
            state <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Input during dummy clocks is don't care
          if (rise) begin
            cnt <= 5'(cnt + 5'h01);
            if (5'(cnt + 5'h01) == {1'b0, cmd.dummy}) begin
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: state <= ST_DATA;
        ST_IGNORE: state <= ST_IGNORE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Four-line command mode and continuous mode
  // --------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      qpi <= 1'b0;
      cont <= 1'b0;
      ones_seen <= 1'b1;
    end else begin
      if (state == ST_IDLE) begin
        ones_seen <= 1'b1;
      end else if (rise && !dq_s[0]) begin
        ones_seen <= 1'b0;
      end
      if (cmd_done && op_now == `SFR_OP_ENTER_QPI && !busy_i) begin
        qpi <= 1'b1;
      end else if (cmd_done && op_now == `SFR_OP_ALL_ONES) begin
        qpi <= 1'b0;
      end
      if (mode_done) begin
        cont <= (next_sh[7:4] == ~next_sh[3:0]);
      end else if (cs_rise && state == ST_ADDR && cont && ones_seen && cnt != 5'h00) begin
        // An all-ones frame too short for an address is the escape
        cont <= 1'b0;
      end
    end
  end

  assign qpi_mode_o = qpi;
  assign cont_mode_o = cont;

  // --------------------------------------------------------------------
  // Array fetch engine
  // --------------------------------------------------------------------
  logic fetch_en;
  logic fire;
  logic arrive;
  logic pop;
  logic [1:0] outstanding;
  logic [1:0] inflight;
  logic [1:0] drop;
  logic [1:0] next_outstanding;
  logic [1:0] next_inflight;
  logic [1:0] next_drop;
  logic next_fetch_en;
  logic buf_valid;
  logic [7:0] buf_data;

  assign fire = fetch_valid_o & fetch_ready_i;
  assign arrive = array_valid_i & array_ready_o;

  always_comb begin
    next_inflight = 2'(inflight + {1'b0, fire} - {1'b0, arrive});
    next_outstanding = cs_s ? 2'h0 : 2'(outstanding + {1'b0, fire} - {1'b0, pop});
    next_drop = drop;
    if (cs_rise) begin
      next_drop = next_inflight;
    end else if (arrive && drop != 2'h0) begin
      next_drop = 2'(drop - 2'h1);
    end
    next_fetch_en = !cs_s && (fetch_en || addr_done);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_en <= 1'b0;
      fetch_valid_o <= 1'b0;
      fetch_addr_o <= 24'h000000;
      outstanding <= 2'h0;
      inflight <= 2'h0;
      drop <= 2'h0;
    end else begin
      fetch_en <= next_fetch_en;
      outstanding <= next_outstanding;
      inflight <= next_inflight;
      drop <= next_drop;
      // Fetch ahead only as far as the buffer can hold
      fetch_valid_o <= next_fetch_en &&
                       (3'({1'b0, next_outstanding} + {1'b0, next_drop}) < 3'(BUF_DEPTH));
      if (addr_done) begin
        fetch_addr_o <= next_sh;
      end else if (fire) begin
        fetch_addr_o <= 24'(fetch_addr_o + 24'h000001);
      end
    end
  end

  sfr_byte_buf #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(cs_s),
    .in_valid_i(array_valid_i && drop == 2'h0),
    .in_data_i(array_data_i),
    .in_ready_o(array_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(pop)
  );

  // --------------------------------------------------------------------
  // Output shifter
  // --------------------------------------------------------------------
  logic [7:0] out_sh;
  logic [3:0] bits_left;
  logic [7:0] load_byte;
  logic shift_now;

  assign shift_now = fall && !cs_s && state == ST_DATA;
  assign pop = shift_now && bits_left == 4'h0 && buf_valid;
  // Late array data shows as an underrun pattern, not a stall
  assign load_byte = buf_valid ? buf_data : `SFR_UNDERRUN_BYTE;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o <= 4'h0;
      dq_oe_o <= 4'h0;
      out_sh <= 8'h00;
      bits_left <= 4'h0;
    end else if (cs_s || state != ST_DATA) begin
      dq_oe_o <= 4'h0;
      dq_o <= 4'h0;
      bits_left <= 4'h0;
    end else if (shift_now) begin
      dq_oe_o <= lane_mask(cmd.data_lanes);
      if (bits_left == 4'h0) begin
        dq_o <= lane_bits(load_byte, cmd.data_lanes);
        out_sh <= 8'(load_byte << cmd.data_lanes);
        bits_left <= 4'(`SFR_BYTE_BITS - {1'b0, cmd.data_lanes});
      end else begin
        dq_o <= lane_bits(out_sh, cmd.data_lanes);
        out_sh <= 8'(out_sh << cmd.data_lanes);
        bits_left <= 4'(bits_left - {1'b0, cmd.data_lanes});
      end
    end
  end

  // --------------------------------------------------------------------
  // Protect and hold pins
  // --------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      write_protect_o <= 1'b0;
      hold_o <= 1'b0;
    end else begin
      // Host keeps lanes two and three high in single-lane reads without enable
      write_protect_o <= !quad_enable_i && !dq_s[2];
      hold_o <= !quad_enable_i && !dq_s[3] && !cs_s;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_cs_release;
    @(posedge clock_i) disable iff (rst_i) cs_rise |=> (dq_oe_o == 4'h0) && (state == ST_IDLE);
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("lines driven after deselect");

  property p_addr_wrap;
    @(posedge clock_i) disable iff (rst_i)
      fire && !addr_done && fetch_addr_o == 24'hFFFFFF |=> fetch_addr_o == 24'h000000;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap");

  property p_addr_step;
    @(posedge clock_i) disable iff (rst_i)
      fire && !addr_done |=> fetch_addr_o == 24'($past(fetch_addr_o) + 24'h000001);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not advance");

  property p_busy_refuse;
    @(posedge clock_i) disable iff (rst_i) cmd_done && busy_i |=> state == ST_IGNORE;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("read taken while busy");

  property p_quiet_dummy;
    @(posedge clock_i) disable iff (rst_i) state inside {ST_MODE, ST_DUMMY} |-> dq_oe_o == 4'h0;
  endproperty
  a_quiet_dummy: assert property (p_quiet_dummy) else $error("driving in dummy phase");

  property p_cont_enter;
    @(posedge clock_i) disable iff (rst_i)
      mode_done && next_sh[7:4] == ~next_sh[3:0] |=> cont ##1 1'b1;
  endproperty
  a_cont_enter: assert property (p_cont_enter) else $error("continuous mode not entered");

  property p_cont_leave;
    @(posedge clock_i) disable iff (rst_i) mode_done && next_sh[7:4] == next_sh[3:0] |=> !cont;
  endproperty
  a_cont_leave: assert property (p_cont_leave) else $error("continuous mode not left");

  property p_cont_skip;
    @(posedge clock_i) disable iff (rst_i) cont && state == ST_IDLE && !cs_s |=> state == ST_ADDR;
  endproperty
  a_cont_skip: assert property (p_cont_skip) else $error("opcode not skipped");

  property p_single_lane;
    @(posedge clock_i) disable iff (rst_i)
      shift_now && cmd.data_lanes == `SFR_LANES_1 |=> dq_oe_o == `SFR_MASK_1;
  endproperty
  a_single_lane: assert property (p_single_lane) else $error("single read lane wrong");

  property p_quad_lane;
    @(posedge clock_i) disable iff (rst_i)
      shift_now && cmd.data_lanes == `SFR_LANES_4 |=> dq_oe_o == `SFR_MASK_4;
  endproperty
  a_quad_lane: assert property (p_quad_lane) else $error("quad read lanes wrong");

  property p_qpi_enter;
    @(posedge clock_i) disable iff (rst_i)
      cmd_done && op_now == `SFR_OP_ENTER_QPI && !busy_i |=> qpi;
  endproperty
  a_qpi_enter: assert property (p_qpi_enter) else $error("four-line mode not entered");

  c_cont_data: cover property (@(posedge clock_i) disable iff (rst_i) cont && state == ST_DATA);
  c_end_in_data: cover property (@(posedge clock_i) disable iff (rst_i) cs_rise && $past(state == ST_DATA));
  c_busy_read: cover property (@(posedge clock_i) disable iff (rst_i) cmd_done && busy_i && cmd_now.ok);
  c_qpi_data: cover property (@(posedge clock_i) disable iff (rst_i) qpi && state == ST_DATA);

endmodule : sfr_read_front
`default_nettype wire

// *** include/sfr_params.svh ***
// Opcodes, phase lengths and defaults for the serial flash read front end
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DUAL_OUT 8'h3B
`define SFR_OP_DUAL_IO 8'hBB
`define SFR_OP_QUAD_OUT 8'h6B
`define SFR_OP_QUAD_IO 8'hEB
`define SFR_OP_ENTER_QPI 8'h38
`define SFR_OP_ALL_ONES 8'hFF

// ----------------------------------------------------------------------
// Phase lengths (bits for opcode, address, mode; clocks for dummy)
// ----------------------------------------------------------------------
`define SFR_OP_BITS 5'h08
`define SFR_ADDR_BITS 5'h18
`define SFR_MODE_BITS 5'h08
`define SFR_SPI_DUMMY 4'h8
`define SFR_DIO_DUMMY 4'h4
`define SFR_QIO_DUMMY 4'h4
`define SFR_QPI_FAST_DUMMY 4'h6

// ----------------------------------------------------------------------
// Lane counts, masks and defaults
// ----------------------------------------------------------------------
`define SFR_LANES_1 3'h1
`define SFR_LANES_2 3'h2
`define SFR_LANES_4 3'h4
`define SFR_MASK_1 4'h2
`define SFR_MASK_2 4'h3
`define SFR_MASK_4 4'hF
`define SFR_BUF_DEPTH 2
`define SFR_BYTE_BITS 4'h8
`define SFR_UNDERRUN_BYTE 8'hFF
`define SFR_SYNC_RESET 6'h10

`endif

// *** include/sfr_pkg.sv ***
// Types shared by the serial flash read front end
package sfr_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_MODE = 7'h08,
    ST_DUMMY = 7'h10,
    ST_DATA = 7'h20,
    ST_IGNORE = 7'h40
  } sfr_state_t;

  typedef logic [2:0] sfr_lanes_t;

  typedef struct packed {
    logic ok;
    sfr_lanes_t addr_lanes;
    sfr_lanes_t data_lanes;
    logic [3:0] dummy;
    logic has_mode;
  } sfr_cmd_t;

endpackage : sfr_pkg

// *** tb/sfr_host_model.sv ***
// SPI host model for the serial flash read front end
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  input wire logic [3:0] dq_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] hdq_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    hdq_o = 4'h0;
  end
  // ---------------------------------------------
  // Link clock of 64 ns, still between frames
  // ---------------------------------------------
  // Released lanes toggle so a stale level never reads as data
  task automatic clk(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
    hdq_o = (v & oe) | (~hdq_o & ~oe);
    #32 sclk_o = 1'b1;
    #31 s = dq_i;
    #1 sclk_o = 1'b0;
  endtask : clk
  task automatic send(input logic [31:0] v, input int l, input int n);
    logic [3:0] s;
    logic [31:0] g;
    for (int k = n - 1; k >= 0; k--) begin
      g = v >> (k * l);
      if (l == 1) clk({2'b11, 1'b0, g[0]}, 4'hD, s);
      else clk(g[3:0], (l == 2) ? 4'h3 : 4'hF, s);
    end
  endtask : send
  task automatic recv(input int l, input int n, output logic [31:0] r);
    logic [3:0] s;
    r = 32'h0;
    for (int k = 0; k < n; k++) begin
      clk(4'h0, 4'h0, s);
      r = (l == 1) ? {r[30:0], s[1]} : (l == 2) ? {r[29:0], s[1:0]} : {r[27:0], s};
    end
  endtask : recv
  task automatic sel(input logic hi);
    cs_n_o = hi;
    #64;
  endtask : sel
endmodule : sfr_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the serial flash read front end
`timescale 1ns/1ps
`default_nettype none
`include "sfr_params.svh"
module tb_top;
  import sfr_pkg::*;
  logic clock_i;
  logic rst_i;
  logic busy_i;
  logic qe;
  logic fetch_ready_i = 1'b0;
  logic array_valid_i = 1'b0;
  logic [7:0] array_data_i = 8'h00;
  logic [3:0] dq_o, dq_oe_o, hdq, dq_w;
  logic sclk, cs_n, wp, hold, qpi, cont, fv, ar;
  logic [23:0] fa;
  logic [31:0] r;
  logic [23:0] q[$];
  int n_errors = 0;
  int num_checks = 0;
  assign dq_w = (dq_oe_o & dq_o) | (~dq_oe_o & hdq);
  sfr_read_front sfr_read_front_i (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sclk_i(sclk),
    .cs_n_i(cs_n),
    .dq_i(dq_w),
    .busy_i(busy_i),
    .quad_enable_i(qe),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .write_protect_o(wp),
    .hold_o(hold),
    .qpi_mode_o(qpi),
    .cont_mode_o(cont),
    .fetch_valid_o(fv),
    .fetch_addr_o(fa),
    .fetch_ready_i(fetch_ready_i),
    .array_valid_i(array_valid_i),
    .array_data_i(array_data_i),
    .array_ready_o(ar)
  );
  sfr_host_model sfr_host_model_i (.dq_i(dq_w), .sclk_o(sclk), .cs_n_o(cs_n), .hdq_o(hdq));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // ---------------------------------------------
  // Array stand-in on the falling edge, stalling every other cycle
  // ---------------------------------------------
  always @(negedge clock_i) begin
    // Answer first, so a request never gets its byte at its own edge
    array_valid_i = q.size() != 0;
    array_data_i = (q.size() != 0) ? 8'(q[0][7:0] + q[0][23:16]) : 8'h00;
    if (array_valid_i && ar) void'(q.pop_front());
    fetch_ready_i = ~fetch_ready_i;
    if (fv && fetch_ready_i) q.push_back(fa);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Opcode 00 stands for an opcode-free continuous frame
  task automatic rd(input string nm, input logic [7:0] op, input logic [23:0] a, input int al,
                    input int mn, input logic [7:0] md, input int dm, input int dl,
                    input int dn, input logic [31:0] exp);
    sfr_host_model_i.sel(1'b0);
    if (op != 8'h00) sfr_host_model_i.send(op, 1, 8);
    sfr_host_model_i.send(a, al, 24 / al);
    if (mn != 0) sfr_host_model_i.send(md, 4, 2);
    sfr_host_model_i.recv(1, dm, r);
    if (dm != 0) chk({nm, " oe dummy"}, dq_oe_o, 4'h0);
    sfr_host_model_i.recv(dl, dn, r);
    chk(nm, r, exp);
    sfr_host_model_i.sel(1'b1);
    chk({nm, " oe idle"}, dq_oe_o, 4'h0);
    $display("test %s done", nm);
  endtask : rd
  task automatic t_busy(input logic [7:0] op);
    busy_i = 1'b1;
    sfr_host_model_i.sel(1'b0);
    sfr_host_model_i.send(op, 1, 8);
    sfr_host_model_i.send(24'h000000, 1, 24);
    sfr_host_model_i.recv(1, 8, r);
    chk("busy oe", dq_oe_o, 4'h0);
    chk("busy fetch", fv, 1'b0);
    sfr_host_model_i.sel(1'b1);
    busy_i = 1'b0;
    $display("test busy %h done", op);
  endtask : t_busy
  task automatic t_escape;
    sfr_host_model_i.sel(1'b0);
    sfr_host_model_i.send(`SFR_OP_ALL_ONES, 4, 2);
    sfr_host_model_i.sel(1'b1);
    chk("escape", cont, 1'b0);
    $display("test escape done");
  endtask : t_escape
  task automatic t_qpi;
    sfr_host_model_i.sel(1'b0);
    sfr_host_model_i.send(`SFR_OP_ENTER_QPI, 1, 8);
    sfr_host_model_i.sel(1'b1);
    chk("qpi on", qpi, 1'b1);
    sfr_host_model_i.sel(1'b0);
    sfr_host_model_i.send(`SFR_OP_QUAD_IO, 4, 2);
    sfr_host_model_i.send(24'h000080, 4, 6);
    sfr_host_model_i.send(8'h00, 4, 2);
    sfr_host_model_i.recv(4, 4, r);
    sfr_host_model_i.recv(4, 2, r);
    chk("qpi quad io", r, 32'h80);
    sfr_host_model_i.sel(1'b1);
    sfr_host_model_i.sel(1'b0);
    sfr_host_model_i.send(`SFR_OP_FAST, 4, 2);
    sfr_host_model_i.send(24'h000090, 4, 6);
    sfr_host_model_i.recv(4, `SFR_QPI_FAST_DUMMY, r);
    sfr_host_model_i.recv(4, 2, r);
    chk("qpi fast", r, 32'h90);
    sfr_host_model_i.sel(1'b1);
    sfr_host_model_i.sel(1'b0);
    sfr_host_model_i.send(`SFR_OP_ALL_ONES, 4, 2);
    sfr_host_model_i.sel(1'b1);
    chk("qpi off", qpi, 1'b0);
    $display("test qpi done");
  endtask : t_qpi
  initial begin
    rst_i = 1'b1;
    busy_i = 1'b0;
    qe = 1'b0;
    repeat (10) @(posedge clock_i);
    @(negedge clock_i) rst_i = 1'b0;
    repeat (8) @(negedge clock_i);
    chk("protect", wp, 1'b1);
    sfr_host_model_i.sel(1'b0);
    chk("hold", hold, 1'b1);
    sfr_host_model_i.sel(1'b1);
    chk("no hold", hold, 1'b0);
    rd("wrap", `SFR_OP_READ, 24'hFFFFFE, 1, 0, 8'h00, 0, 1, 24, 32'hFDFE00);
    t_busy(`SFR_OP_READ);
    t_busy(`SFR_OP_QUAD_IO);
    rd("fast", `SFR_OP_FAST, 24'h000010, 1, 0, 8'h00, 8, 1, 8, 32'h10);
    rd("dual out", `SFR_OP_DUAL_OUT, 24'h000020, 1, 0, 8'h00, 8, 2, 4, 32'h20);
    rd("dual io", `SFR_OP_DUAL_IO, 24'h012030, 2, 0, 8'h00, 4, 2, 8, 32'h3132);
    rd("quad out", `SFR_OP_QUAD_OUT, 24'h000040, 1, 0, 8'h00, 8, 4, 2, 32'h40);
    qe = 1'b1;
    repeat (8) @(negedge clock_i);
    chk("no protect", wp, 1'b0);
    rd("quad io", `SFR_OP_QUAD_IO, 24'h000050, 4, 2, 8'hA5, 4, 4, 2, 32'h50);
    chk("cont on", cont, 1'b1);
    rd("cont keep", 8'h00, 24'h000058, 4, 2, 8'h5A, 4, 4, 2, 32'h58);
    chk("cont kept", cont, 1'b1);
    t_escape();
    rd("quad io f0", `SFR_OP_QUAD_IO, 24'h000068, 4, 2, 8'hF0, 4, 4, 2, 32'h68);
    chk("cont again", cont, 1'b1);
    rd("cont", 8'h00, 24'h000060, 4, 2, 8'h00, 4, 4, 2, 32'h60);
    chk("cont off", cont, 1'b0);
    rd("after cont", `SFR_OP_READ, 24'h000070, 1, 0, 8'h00, 0, 1, 8, 32'h70);
    t_qpi();
    stop_test();
  end
  initial begin
    #300000;
    n_errors++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
